// ==== src/reset_tick_top.sv ====
// Reset-cause flags, PLL synthesizer write gating and periodic tick.
// Assumes an APB master on clk; cause, lock, oscillator-up and the two
// source clocks arrive as pins from outside this clock domain.
// What this block does
// RL1 - Power-on reset sets the power-on flag, bit 6.
// RL2 - Low-voltage reset on any supply domain sets bit 5.
// RL3 - Operating watchdog reset sets bit 3.
// RL4 - Loss of crystal clock reset sets bit 1.
// RL5 - Loss of PLL clock reset sets bit 0.
// RL6 - Cause flags clear only on writing one; zero leaves them.
// RL7 - Synthesizer writes land only if unlocked and PLL selected.
// RL8 - Any synthesizer write clears lock and oscillator-up status.
// RL9 - Source select zero uses RC clock, one uses crystal clock while oscillator-up status is set, else RC clock.
// RL10 - In stop, counter runs only with pseudo-stop and crystal source.
// RL11 - Any control register write starts a fresh period.
// RL12 - A change of effective source restarts the period.
// RL13 - Bit 7 picks binary or decimal prescaler family.
// RL14 - Bits 6..4 pick prescale rate, bits 3..0 the modulus.
// RL15 - Divide ratio from rate and modulus; rate zero stops counting.
// RL16 - Each expiry sets the tick flag and starts the next period.
`timescale 1ns/10ps
module reset_tick_top import reset_tick_pkg::*; #(
  parameter int BIN_SHIFT = BIN_SHIFT_DEF,
  parameter int DEC_UNIT = DEC_UNIT_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lowVoltReset,
  input wire logic wdogReset,
  input wire logic oscMonReset,
  input wire logic pllMonReset,
  input wire logic pllLock,
  input wire logic oscUp,
  input wire logic rcClk,
  input wire logic crystal_clock,
  input wire logic stopMode,
  output logic periodicTick,
  output logic tickFlag
);
  logic [SY_N-1:0] asyncIn;
  logic [SY_N-1:0] syncA;
  logic [SY_N-1:0] syncB;
  logic [SY_N-1:0] syncC;
  logic [7:0] cause;
  logic [7:0] next_cause;
  logic [7:0] causeSet;
  logic [7:0] clkCfg;
  logic [7:0] synr;
  logic [7:0] perCtrl;
  logic lockStatus;
  logic oscUpStatus;
  logic srcPrev;
  logic expire;
  logic firstCycle;
  logic [7:0] readMux;

  // Pin inputs into one bundle of synchroniser lanes
  assign asyncIn[SY_LVR] = lowVoltReset;
  assign asyncIn[SY_WDOG] = wdogReset;
  assign asyncIn[SY_OSCMON] = oscMonReset;
  assign asyncIn[SY_PLLMON] = pllMonReset;
  assign asyncIn[SY_LOCK] = pllLock;
  assign asyncIn[SY_OSCUP] = oscUp;
  assign asyncIn[SY_RC] = rcClk;
  assign asyncIn[SY_OSC] = crystal_clock;

  // Two flops per lane; a third only serves edge detection after them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end else begin
      syncA <= asyncIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  wire [SY_N-1:0] rise = syncB & ~syncC;

  // APB decode: one wait state, so the answer is a registered flop
  wire [3:0] idx = paddr[ADDR_W-1:2];
  wire aligned = paddr[1:0] == 2'b00;
  wire hitSynr = aligned && idx == IDX_SYNR;
  wire hitPer = aligned && idx == IDX_PERIODIC;
  wire hitCause = aligned && idx == IDX_CAUSE;
  wire hitCfg = aligned && idx == IDX_CLKCFG;
  wire hitStatus = aligned && idx == IDX_STATUS;
  wire mapped = hitSynr | hitPer | hitCause | hitCfg | hitStatus;
  wire answer = psel && penable && !pready;
  wire access = psel && penable && pready;
  wire wrEn = access && pwrite;

  // Write strobes; an unmapped address changes nothing
  wire synrWrite = wrEn && hitSynr;
  wire perWrite = wrEn && hitPer;
  wire causeWrite = wrEn && hitCause;
  wire cfgWrite = wrEn && hitCfg;
  wire statusWrite = wrEn && hitStatus;
  wire synrAllowed = !clkCfg[CFG_LOCK] && clkCfg[CFG_PLL_CLK];

  // Read selection
  wire [7:0] statusView = {5'h00, tickFlag, oscUpStatus, lockStatus};
  assign readMux = hitSynr ? synr :
                   hitPer ? perCtrl :
                   hitCause ? cause :
                   hitCfg ? clkCfg :
                   hitStatus ? statusView : 8'h00;

  // Answer the access phase one cycle in; slave error on unmapped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= answer;
      pslverr <= answer && !mapped;
      prdata <= answer && !pwrite ? {24'h000000, readMux} : '0;
    end
  end

  // Hardware set sources, held at their documented bit positions
  always_comb begin
    causeSet = 8'h00;
    causeSet[CAUSE_LVR] = syncB[SY_LVR]; // see RL2
    causeSet[CAUSE_WDOG] = syncB[SY_WDOG]; // see RL3
    causeSet[CAUSE_OSCMON] = syncB[SY_OSCMON]; // see RL4
    causeSet[CAUSE_PLLMON] = syncB[SY_PLLMON]; // see RL5
  end

  // Write one clears, zero keeps; a set in the same cycle wins
  wire [7:0] causeClr = causeWrite ? (pwdata[7:0] & CAUSE_MASK) : 8'h00;
  assign next_cause = (cause & ~causeClr) | causeSet; // see RL6

  // rst is the power-on reset, so it leaves the power-on flag set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause <= CAUSE_RESET; // see RL1
    end else begin
      cause <= next_cause;
    end
  end

  // Clock configuration and the gated synthesizer register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkCfg <= CLKCFG_RESET;
      synr <= SYNR_RESET;
    end else begin
      if (cfgWrite) begin
        clkCfg <= pwdata[7:0] & CLKCFG_MASK;
      end
      if (synrWrite && synrAllowed) begin // see RL7
        synr <= pwdata[7:0];
      end
    end
  end

  // Status follows the pins, but any synthesizer write drops it until
  // the next rising edge; a rise in the write cycle still wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lockStatus <= 1'b0;
      oscUpStatus <= 1'b0;
    end else begin
      if (rise[SY_LOCK]) begin
        lockStatus <= 1'b1;
      end else if (synrWrite || !syncB[SY_LOCK]) begin // see RL8
        lockStatus <= 1'b0;
      end
      if (rise[SY_OSCUP]) begin
        oscUpStatus <= 1'b1;
      end else if (synrWrite || !syncB[SY_OSCUP]) begin // see RL8
        oscUpStatus <= 1'b0;
      end
    end
  end

  // Crystal source counts only while the oscillator is reported up
  wire srcEff = clkCfg[CFG_SRC] && oscUpStatus;
  wire srcTick = srcEff ? rise[SY_OSC] : rise[SY_RC]; // see RL9
  wire runOk = !stopMode || (clkCfg[CFG_PSEUDO_STOP] && srcEff); // see RL10
  wire restart = perWrite || (srcEff != srcPrev); // see RL11, RL12

  // Periodic control register and source history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      perCtrl <= PER_RESET;
      srcPrev <= 1'b0;
    end else begin
      srcPrev <= srcEff;
      if (perWrite) begin
        perCtrl <= pwdata[7:0];
      end
    end
  end

  periodic_counter #(
    .CNT_W(32),
    .BIN_SHIFT(BIN_SHIFT),
    .DEC_UNIT(DEC_UNIT)
  ) u_counter (
    .clk(clk),
    .rst(rst),
    .srcTick(srcTick),
    .run(runOk),
    .restart(restart),
    .decimal(perCtrl[PER_DEC]), // see RL13
    .rate(perCtrl[PER_RATE_HI:PER_RATE_LO]), // see RL14
    .modulus(perCtrl[PER_MOD_HI:0]),
    .expire(expire)
  );

  // Tick flag: sticky, write one to clear, expiry wins over the clear
  wire tickClr = statusWrite && pwdata[ST_TICK];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tickFlag <= 1'b0;
      periodicTick <= 1'b0;
    end else begin
      periodicTick <= expire; // see RL16
      if (expire) begin
        tickFlag <= 1'b1;
      end else if (tickClr) begin
        tickFlag <= 1'b0;
      end
    end
  end

  // Marks the first cycle after reset release for checking only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      firstCycle <= 1'b1;
    end else begin
      firstCycle <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_por_flag;
    firstCycle |-> cause[CAUSE_POR];
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag clear"); // see RL1

  property p_lvr_set;
    syncB[SY_LVR] |=> cause[CAUSE_LVR];
  endproperty
  a_lvr_set: assert property (p_lvr_set) else $error("low-voltage flag lost"); // see RL2

  property p_wdog_set;
    syncB[SY_WDOG] |=> cause[CAUSE_WDOG];
  endproperty
  a_wdog_set: assert property (p_wdog_set) else $error("watchdog flag lost"); // see RL3

  property p_mon_set;
    syncB[SY_OSCMON] |=> cause[CAUSE_OSCMON];
  endproperty
  a_mon_set: assert property (p_mon_set) else $error("oscillator monitor flag lost"); // see RL4

  property p_pll_set;
    $rose(syncB[SY_PLLMON]) ##1 !causeWrite |-> cause[CAUSE_PLLMON] [*2];
  endproperty
  a_pll_set: assert property (p_pll_set) else $error("PLL monitor flag lost"); // see RL5

  property p_zero_keeps;
    cause[CAUSE_WDOG] && !(causeWrite && pwdata[CAUSE_WDOG]) |=> cause[CAUSE_WDOG];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag cleared by zero"); // see RL6

  property p_one_clears;
    causeWrite && pwdata[CAUSE_POR] |=> !cause[CAUSE_POR];
  endproperty
  a_one_clears: assert property (p_one_clears) else $error("flag not cleared"); // see RL6

  property p_synr_block;
    synrWrite && !synrAllowed |=> $stable(synr);
  endproperty
  a_synr_block: assert property (p_synr_block) else $error("locked write landed"); // see RL7

  property p_synr_clear;
    synrWrite && !rise[SY_LOCK] && !rise[SY_OSCUP] |=> !lockStatus && !oscUpStatus;
  endproperty
  a_synr_clear: assert property (p_synr_clear) else $error("status kept after write"); // see RL8

  property p_src_rc;
    !clkCfg[CFG_SRC] |-> srcTick == rise[SY_RC];
  endproperty
  a_src_rc: assert property (p_src_rc) else $error("wrong source clock"); // see RL9

  property p_tick_flag;
    expire |=> tickFlag && periodicTick ##1 !periodicTick;
  endproperty
  a_tick_flag: assert property (p_tick_flag) else $error("expiry not flagged"); // see RL16

  property p_answer;
    answer |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("APB answer timing");

  c_synr_write: cover property (synrWrite && synrAllowed);
  c_cause_clear: cover property (causeWrite && |(cause & pwdata[7:0]));
  c_tick: cover property (periodicTick);
  c_unmapped: cover property (pslverr);
endmodule : reset_tick_top

// ==== src/reset_tick_pkg.sv ====
// Shared constants for the reset-cause and periodic tick block.
// Assumes a 32-bit APB slave port with word-indexed registers.
package reset_tick_pkg;
  // Register indices; byte address is four times the index
  localparam int ADDR_W = 6;
  localparam logic [3:0] IDX_SYNR = 4'h4;
  localparam logic [3:0] IDX_PERIODIC = 4'hb;
  localparam logic [3:0] IDX_CAUSE = 4'hc;
  localparam logic [3:0] IDX_CLKCFG = 4'hd;
  localparam logic [3:0] IDX_STATUS = 4'he;
  // Reset-cause flag positions and values
  localparam int CAUSE_POR = 6;
  localparam int CAUSE_LVR = 5;
  localparam int CAUSE_WDOG = 3;
  localparam int CAUSE_OSCMON = 1;
  localparam int CAUSE_PLLMON = 0;
  localparam logic [7:0] CAUSE_MASK = 8'h6b;
  localparam logic [7:0] CAUSE_RESET = 8'h40;
  // Clock configuration fields
  localparam int CFG_PLL_CLK = 0;
  localparam int CFG_SRC = 1;
  localparam int CFG_PSEUDO_STOP = 2;
  localparam int CFG_LOCK = 3;
  localparam logic [7:0] CLKCFG_MASK = 8'h0f;
  localparam logic [7:0] CLKCFG_RESET = 8'h00;
  // Status fields
  localparam int ST_LOCK = 0;
  localparam int ST_OSCUP = 1;
  localparam int ST_TICK = 2;
  // Periodic control fields and other reset values
  localparam int PER_DEC = 7;
  localparam int PER_RATE_HI = 6;
  localparam int PER_RATE_LO = 4;
  localparam int PER_MOD_HI = 3;
  localparam logic [7:0] PER_RESET = 8'h00;
  localparam logic [7:0] SYNR_RESET = 8'h00;
  // Synchroniser lanes for pin inputs
  localparam int SY_LVR = 0;
  localparam int SY_WDOG = 1;
  localparam int SY_OSCMON = 2;
  localparam int SY_PLLMON = 3;
  localparam int SY_LOCK = 4;
  localparam int SY_OSCUP = 5;
  localparam int SY_RC = 6;
  localparam int SY_OSC = 7;
  localparam int SY_N = 8;
  // Prescaler defaults
  localparam int BIN_SHIFT_DEF = 9;
  localparam int DEC_UNIT_DEF = 1000;

  // Decimal family multiplier per rate code; zero means stopped
  function automatic int dec_mult(input logic [2:0] rate);
    case (rate)
      3'h1: dec_mult = 1;
      3'h2: dec_mult = 2;
      3'h3: dec_mult = 5;
      3'h4: dec_mult = 10;
      3'h5: dec_mult = 20;
      3'h6: dec_mult = 50;
      3'h7: dec_mult = 100;
      default: dec_mult = 0;
    endcase
  endfunction : dec_mult
endpackage : reset_tick_pkg

// ==== src/periodic_counter.sv ====
// Prescaler and modulus counter of the periodic tick.
// Assumes srcTick is a one-cycle pulse on clk per source clock edge.
`timescale 1ns/10ps
module periodic_counter import reset_tick_pkg::*; #(
  parameter int CNT_W = 32,
  parameter int BIN_SHIFT = BIN_SHIFT_DEF,
  parameter int DEC_UNIT = DEC_UNIT_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic srcTick,
  input wire logic run,
  input wire logic restart,
  input wire logic decimal,
  input wire logic [2:0] rate,
  input wire logic [3:0] modulus,
  output logic expire
);
  localparam logic [CNT_W-1:0] ONE = 1;
  logic [CNT_W-1:0] pre;
  logic [CNT_W-1:0] preLimit;
  logic [3:0] modCnt;

  // Refuse sizes whose largest binary prescale cannot be held
  if (BIN_SHIFT + 6 >= CNT_W || DEC_UNIT < 1 || CNT_W > 32) begin : g_bad
    $error("periodic_counter: prescale does not fit CNT_W");
  end

  // Prescale per family; rate zero yields zero, which stops the count
  always_comb begin
    if (rate == 3'h0) begin
      preLimit = '0;
    end else if (decimal) begin // see RL13
      preLimit = CNT_W'(DEC_UNIT * dec_mult(rate));
    end else begin
      preLimit = ONE << (BIN_SHIFT + int'(rate) - 1);
    end
  end

  wire preWrap = (pre + ONE) == preLimit;
  wire modWrap = modCnt == modulus; // see RL14
  wire advance = run && (rate != 3'h0) && srcTick; // see RL10, RL15

  // Restart wins over counting so a write never leaves a partial period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= '0;
      modCnt <= 4'h0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (restart) begin // see RL11, RL12
        pre <= '0;
        modCnt <= 4'h0;
      end else if (advance) begin
        if (preWrap) begin
          pre <= '0;
          if (modWrap) begin // see RL16
            modCnt <= 4'h0;
            expire <= 1'b1;
          end else begin
            modCnt <= modCnt + 4'h1;
          end
        end else begin
          pre <= pre + ONE;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_halt;
    !run && !restart |=> $stable(pre) && $stable(modCnt);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted"); // see RL10

  property p_restart;
    restart |=> pre == '0 && modCnt == 4'h0 && !expire;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear"); // see RL11

  property p_rate_off;
    rate == 3'h0 && !restart |=> $stable(pre) && !expire;
  endproperty
  a_rate_off: assert property (p_rate_off) else $error("rate zero counted"); // see RL15

  property p_expire;
    advance && preWrap && modWrap && !restart |=> expire ##1 !expire;
  endproperty
  a_expire: assert property (p_expire) else $error("expire not one pulse"); // see RL16

  c_expire: cover property (expire);
endmodule : periodic_counter

// ==== sim/tb_top.sv ====
// Self-checking bench for reset_tick_top: APB master tasks, cause pins and periodic tick.
// Assumes the design package and top module are compiled before this file.
`timescale 1ns/10ps
module tb_top import reset_tick_pkg::*; ;
  localparam int BSH = 1;
  localparam int DEC = 1;
  localparam int RC_PER = 10;
  localparam int OSC_PER = 14;
  localparam int DEC_TAB[8] = '{0, 1, 2, 5, 10, 20, 50, 100};
  localparam int CBIT[4] = '{CAUSE_LVR, CAUSE_WDOG, CAUSE_OSCMON, CAUSE_PLLMON};
  localparam logic [5:0] A_SYNR = {IDX_SYNR, 2'b00};
  localparam logic [5:0] A_PER = {IDX_PERIODIC, 2'b00};
  localparam logic [5:0] A_CAUSE = {IDX_CAUSE, 2'b00};
  localparam logic [5:0] A_CFG = {IDX_CLKCFG, 2'b00};
  localparam logic [5:0] A_STAT = {IDX_STATUS, 2'b00};
  localparam logic [5:0] A_BAD = 6'h3c;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] causePins = 4'h0;
  logic pllLock = 1'b0;
  logic oscUp = 1'b0;
  logic rcClk = 1'b0;
  logic crystal_clock = 1'b0;
  logic stopMode = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, periodicTick, tickFlag;
  logic [31:0] q;
  logic err;
  int fail_count = 0;
  int compares = 0;
  int ticks = 0;

  reset_tick_top #(.BIN_SHIFT(BSH), .DEC_UNIT(DEC)) DUT (.clk(clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lowVoltReset(causePins[0]), .wdogReset(causePins[1]),
    .oscMonReset(causePins[2]), .pllMonReset(causePins[3]), .pllLock(pllLock), .oscUp(oscUp),
    .rcClk(rcClk), .crystal_clock(crystal_clock), .stopMode(stopMode), .periodicTick(periodicTick),
    .tickFlag(tickFlag));

  // Bus clock and two slow source clocks, offset so they never line up with clk
  always #20 clk = ~clk;
  initial begin
    #7;
    forever #(RC_PER * 20) rcClk = ~rcClk;
  end
  initial begin
    #11;
    forever #(OSC_PER * 20) crystal_clock = ~crystal_clock;
  end
  // Tick pulses are counted mid-cycle, where they have settled
  always @(negedge clk) if (periodicTick === 1'b1) ticks++;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Cycle and tick counts from the bench's own counters
  task automatic check_count(input int got, input int exp);
    compares++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : check_count

  // One APB transfer; the wait is bounded since the slave owns the answer time
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) check(32'h0, 32'h1);
  endtask : apb

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd

  // Reference divide: source edges per period
  function automatic int edges(input logic [7:0] r);
    if (r[6:4] == 3'h0) return 0;
    if (r[7]) return DEC_TAB[r[6:4]] * DEC * (r[3:0] + 1);
    return (2 ** (BSH + r[6:4] - 1)) * (r[3:0] + 1);
  endfunction : edges

  task automatic tickrun(input logic [7:0] cfgv, input logic [7:0] r, input int per);
    int c;
    c = 0;
    apb(1'b1, A_CFG, {24'h0, cfgv});
    apb(1'b1, A_PER, {24'h0, r});
    // A tick launched by the old setting may still stand; let it pass
    @(negedge clk);
    do begin
      @(negedge clk);
      c++;
    end while (periodicTick !== 1'b1 && c < 4000);
    check(tickFlag, 1'b1);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (periodicTick !== 1'b1 && c < 4000);
    check_count(c, edges(r) * per);
  endtask : tickrun

  // Skips three cycles so a tick already in flight is not blamed
  task automatic quiet(input int n);
    int t0;
    repeat (3) @(negedge clk);
    t0 = ticks;
    repeat (n) @(negedge clk);
    check_count(ticks - t0, 0);
  endtask : quiet

  // Restart pressure: writes come faster than one period, so no tick may appear
  task automatic hold(input logic src);
    int t0;
    t0 = 0;
    for (int j = 0; j < 7; j++) begin
      // Source flips on every write, the first one included
      if (src) apb(1'b1, A_CFG, {30'h0, ~j[0], 1'b0});
      else apb(1'b1, A_PER, 32'h13);
      if (j == 0) begin
        repeat (3) @(negedge clk);
        t0 = ticks;
      end
      repeat (30) @(negedge clk);
    end
    check_count(ticks - t0, 0);
  endtask : hold

  task automatic wrap_up;
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    int cause;
    int synr;
    int r;
    int cf[4];
    logic [7:0] rv;
    cause = 32'h40;
    synr = 0;
    cf = '{1, 0, 9, 8};
    void'($urandom(32'h0e6f));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pllLock <= 1'b1;
    oscUp <= 1'b1;
    rd(A_CAUSE, cause);
    rd(A_PER, 32'h0);
    $display("Test reset values done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      causePins[k] <= 1'b1;
      repeat (6) @(posedge clk);
      causePins[k] <= 1'b0;
      repeat (4) @(posedge clk);
      cause |= 1 << CBIT[k];
      rd(A_CAUSE, cause);
    end
    apb(1'b1, A_CAUSE, 32'h0);
    rd(A_CAUSE, cause);
    r = $urandom & 32'hff;
    apb(1'b1, A_CAUSE, r);
    cause &= ~r;
    rd(A_CAUSE, cause);
    apb(1'b1, A_CAUSE, 32'hff);
    rd(A_CAUSE, 32'h0);
    // A second power-on reset in mid-run must raise the flag again
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(A_CAUSE, 32'h40);
    apb(1'b0, A_BAD, 32'h0);
    check(err, 1'b1);
    check(q, 32'h0);
    $display("Test cause flags done");
    for (int i = 0; i < 6; i++) begin
      rv = {i[1], 3'(1 + $urandom % 7), 4'($urandom % 2)};
      tickrun(i[0] ? 8'h2 : 8'h0, rv, i[0] ? OSC_PER : RC_PER);
    end
    apb(1'b1, A_PER, 32'h03);
    quiet(400);
    $display("Test periodic rates done");
    @(posedge clk);
    stopMode <= 1'b1;
    tickrun(8'h6, 8'h11, OSC_PER);
    apb(1'b1, A_CFG, 32'h2);
    quiet(300);
    apb(1'b1, A_CFG, 32'h4);
    quiet(300);
    @(posedge clk);
    stopMode <= 1'b0;
    $display("Test stop mode done");
    hold(1'b0);
    hold(1'b1);
    $display("Test restart done");
    apb(1'b1, A_PER, 32'h0);
    repeat (4) @(posedge clk);
    apb(1'b1, A_STAT, 32'h4);
    rd(A_STAT, 32'h3);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_CFG, cf[i]);
      rv = 8'($urandom);
      apb(1'b1, A_SYNR, {24'h0, rv});
      if (cf[i] == 1) synr = rv;
      rd(A_SYNR, synr);
      rd(A_STAT, 32'h0);
    end
    $display("Test synthesizer gating done");
    wrap_up();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_top
